// File: adc_decode.sv
`timescale 1ns/1ps

// Functional notes
// RQ1 - result written to destination is destination plus source plus carry flag
// RQ2 - opcodes 12h to 17h decode to the six plain operand forms
// RQ3 - flags c z s v h follow the result; decimal-adjust flag always cleared
// RQ4 - plain forms fetch 2 or 3 cycles, execute 3, or 4 if indirect
// RQ5 - opcodes 18h and 19h are extended forms, 4 fetch and 3 execute cycles
module adc_decode (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] OPCODE,
    input wire logic OPCODE_VALID,
    input wire logic [7:0] DST_DATA,
    input wire logic [7:0] SRC_DATA,
    input wire logic [7:0] FLAGS_IN,
    output logic BUSY,
    output logic [2:0] FETCH_CYCLES,
    output logic [2:0] EXEC_CYCLES,
    output logic [1:0] DST_MODE,
    output logic [1:0] SRC_MODE,
    output logic ILLEGAL,
    output logic WB_VALID,
    output logic [7:0] WB_DATA,
    output logic FLAGS_WE,
    output logic [7:0] FLAGS_OUT
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_EXEC
    } adc_state_type;

    adc_state_type state_r, state_nxt;
    adc_pkg::adc_decode_type dec, dec_r;
    adc_pkg::adc_result_type res;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    wire logic take;
    wire logic last;

    // =========================================================
    // opcode decode
    always_comb begin
        dec = '0;
        dec.valid = 1'b1;
        case (OPCODE)
            adc_pkg::OP_RR: begin // RQ2
                dec.fetch_cycles = adc_pkg::FETCH_SHORT; // RQ4
                dec.exec_cycles = adc_pkg::EXEC_DIRECT;
            end
            adc_pkg::OP_RIR: begin
                dec.src_mode = adc_pkg::ADC_MODE_INDIRECT;
                dec.fetch_cycles = adc_pkg::FETCH_SHORT;
                dec.exec_cycles = adc_pkg::EXEC_INDIRECT;
            end
            adc_pkg::OP_GG: begin
                dec.fetch_cycles = adc_pkg::FETCH_LONG;
                dec.exec_cycles = adc_pkg::EXEC_DIRECT;
            end
            adc_pkg::OP_GIG: begin
                dec.src_mode = adc_pkg::ADC_MODE_INDIRECT;
                dec.fetch_cycles = adc_pkg::FETCH_LONG;
                dec.exec_cycles = adc_pkg::EXEC_INDIRECT;
            end
            adc_pkg::OP_GIM: begin
                dec.src_mode = adc_pkg::ADC_MODE_IMMEDIATE;
                dec.fetch_cycles = adc_pkg::FETCH_LONG;
                dec.exec_cycles = adc_pkg::EXEC_DIRECT;
            end
            adc_pkg::OP_IGIM: begin
                dec.dst_mode = adc_pkg::ADC_MODE_INDIRECT;
                dec.src_mode = adc_pkg::ADC_MODE_IMMEDIATE;
                dec.fetch_cycles = adc_pkg::FETCH_LONG;
                dec.exec_cycles = adc_pkg::EXEC_INDIRECT;
            end
            adc_pkg::OP_XX: begin // RQ5
                dec.dst_mode = adc_pkg::ADC_MODE_EXTENDED;
                dec.src_mode = adc_pkg::ADC_MODE_EXTENDED;
                dec.fetch_cycles = adc_pkg::FETCH_EXT;
                dec.exec_cycles = adc_pkg::EXEC_DIRECT;
            end
            adc_pkg::OP_XIM: begin // RQ5
                dec.dst_mode = adc_pkg::ADC_MODE_EXTENDED;
                dec.src_mode = adc_pkg::ADC_MODE_IMMEDIATE;
                dec.fetch_cycles = adc_pkg::FETCH_EXT;
                dec.exec_cycles = adc_pkg::EXEC_DIRECT;
            end
            default: begin
                dec.valid = 1'b0;
            end
        endcase
    end

    adc_alu adc_alu_inst (
        .dst(DST_DATA),
        .src(SRC_DATA),
        .flags_in(FLAGS_IN),
        .res(res)
    );

    // =========================================================
    // sequencing
    assign take = (state_r == ST_IDLE) && OPCODE_VALID && dec.valid;
    assign last = (cnt_r == 3'h1);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_FETCH;
                    cnt_nxt = dec.fetch_cycles;
                end
            end
            ST_FETCH: begin
                cnt_nxt = cnt_r - 3'h1;
                if (last) begin
                    state_nxt = ST_EXEC;
                    cnt_nxt = dec_r.exec_cycles; // RQ4
                end
            end
            ST_EXEC: begin
                cnt_nxt = cnt_r - 3'h1;
                if (last) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state, counter and latched decode
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            dec_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (take) begin
                dec_r <= dec;
            end
        end
    end

    // registered outputs
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BUSY <= 1'b0;
            FETCH_CYCLES <= 3'h0;
            EXEC_CYCLES <= 3'h0;
            DST_MODE <= 2'h0;
            SRC_MODE <= 2'h0;
            ILLEGAL <= 1'b0;
            WB_VALID <= 1'b0;
            WB_DATA <= 8'h00;
            FLAGS_WE <= 1'b0;
            FLAGS_OUT <= adc_pkg::FLAGS_RESET;
        end else begin
            BUSY <= (state_nxt != ST_IDLE);
            ILLEGAL <= (state_r == ST_IDLE) && OPCODE_VALID && !dec.valid;
            if (take) begin
                FETCH_CYCLES <= dec.fetch_cycles;
                EXEC_CYCLES <= dec.exec_cycles;
                DST_MODE <= dec.dst_mode;
                SRC_MODE <= dec.src_mode;
            end
            WB_VALID <= (state_r == ST_EXEC) && last;
            FLAGS_WE <= (state_r == ST_EXEC) && last;
            if ((state_r == ST_EXEC) && last) begin
                WB_DATA <= res.sum; // RQ1
                FLAGS_OUT <= res.flags; // RQ3
            end
        end
    end

    // =========================================================
    // checks
    sequence s_exec_end;
        (state_r == ST_EXEC) && last;
    endsequence

    property p_sum;
        @(posedge CLK) disable iff (RESET)
        s_exec_end |=> WB_VALID && (WB_DATA == 8'($past(DST_DATA) + $past(SRC_DATA)
            + {7'h00, $past(FLAGS_IN[adc_pkg::FLAG_C])}));
    endproperty
    a_sum: assert property (p_sum) else $error("write-back data wrong"); // RQ1

    property p_decode_plain;
        @(posedge CLK) disable iff (RESET)
        take && (OPCODE >= adc_pkg::OP_RR) && (OPCODE <= adc_pkg::OP_IGIM)
            |=> (FETCH_CYCLES != adc_pkg::FETCH_EXT) && BUSY;
    endproperty
    a_decode_plain: assert property (p_decode_plain) else $error("plain decode wrong"); // RQ2

    property p_dflag;
        @(posedge CLK) disable iff (RESET)
        FLAGS_WE |-> !FLAGS_OUT[adc_pkg::FLAG_D];
    endproperty
    a_dflag: assert property (p_dflag) else $error("decimal flag not cleared"); // RQ3

    property p_zflag;
        @(posedge CLK) disable iff (RESET)
        FLAGS_WE |-> (FLAGS_OUT[adc_pkg::FLAG_Z] == (WB_DATA == 8'h00));
    endproperty
    a_zflag: assert property (p_zflag) else $error("zero flag wrong"); // RQ3

    property p_short_timing;
        @(posedge CLK) disable iff (RESET)
        take && (OPCODE == adc_pkg::OP_RR) |-> ##6 WB_VALID;
    endproperty
    a_short_timing: assert property (p_short_timing) else $error("short form timing"); // RQ4

    property p_indirect_timing;
        @(posedge CLK) disable iff (RESET)
        take && (OPCODE == adc_pkg::OP_GIG) |=> !WB_VALID [*7] ##1 WB_VALID;
    endproperty
    a_indirect_timing: assert property (p_indirect_timing) else $error("indirect timing"); // RQ4

    property p_ext_timing;
        @(posedge CLK) disable iff (RESET)
        take && (OPCODE == adc_pkg::OP_XIM) |-> ##8 WB_VALID;
    endproperty
    a_ext_timing: assert property (p_ext_timing) else $error("extended timing"); // RQ5

    property p_ext_mode;
        @(posedge CLK) disable iff (RESET)
        take && (OPCODE == adc_pkg::OP_XX)
            |=> (DST_MODE == adc_pkg::ADC_MODE_EXTENDED) && (EXEC_CYCLES == adc_pkg::EXEC_DIRECT);
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("extended mode wrong"); // RQ5

endmodule // adc_decode

// File: adc_pkg.sv
package adc_pkg;

    // =========================================================
    // opcodes of the add-with-carry family
    localparam logic [7:0] OP_RR = 8'h12;
    localparam logic [7:0] OP_RIR = 8'h13;
    localparam logic [7:0] OP_GG = 8'h14;
    localparam logic [7:0] OP_GIG = 8'h15;
    localparam logic [7:0] OP_GIM = 8'h16;
    localparam logic [7:0] OP_IGIM = 8'h17;
    localparam logic [7:0] OP_XX = 8'h18;
    localparam logic [7:0] OP_XIM = 8'h19;

    // =========================================================
    // cycle counts
    localparam logic [2:0] FETCH_SHORT = 3'h2;
    localparam logic [2:0] FETCH_LONG = 3'h3;
    localparam logic [2:0] FETCH_EXT = 3'h4;
    localparam logic [2:0] EXEC_DIRECT = 3'h3;
    localparam logic [2:0] EXEC_INDIRECT = 3'h4;

    // =========================================================
    // flag bit positions in the flags byte
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // operand addressing of one side of the instruction
    typedef enum logic [1:0] {
        ADC_MODE_DIRECT,
        ADC_MODE_INDIRECT,
        ADC_MODE_IMMEDIATE,
        ADC_MODE_EXTENDED
    } adc_mode_type;

    // decoded view of one opcode
    typedef struct packed {
        logic valid;
        adc_mode_type dst_mode;
        adc_mode_type src_mode;
        logic [2:0] fetch_cycles;
        logic [2:0] exec_cycles;
    } adc_decode_type;

    // result of one execution
    typedef struct packed {
        logic [7:0] sum;
        logic [7:0] flags;
    } adc_result_type;

endpackage

// File: adc_alu.sv
`timescale 1ns/1ps

// =========================================================
// add-with-carry datapath and flag generation
module adc_alu (
    input wire logic [7:0] dst,
    input wire logic [7:0] src,
    input wire logic [7:0] flags_in,
    output adc_pkg::adc_result_type res
);
    wire logic [8:0] full_sum;
    wire logic [4:0] low_sum;
    wire logic [7:0] sum;
    wire logic ovf;

    // sum of destination, source and carry in
    assign full_sum = {1'b0, dst} + {1'b0, src} + {8'h00, flags_in[adc_pkg::FLAG_C]}; // RQ1
    assign low_sum = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, flags_in[adc_pkg::FLAG_C]};
    assign sum = full_sum[7:0];
    assign ovf = (dst[7] == src[7]) && (sum[7] != dst[7]);

    // flag byte: c z s v from result, d cleared, h from low nibble
    assign res.sum = sum;
    assign res.flags = {full_sum[8], (sum == 8'h00), sum[7], ovf, 1'b0, // RQ3
        low_sum[4], flags_in[1:0]};
endmodule // adc_alu

// File: adc_operand_model.sv
`timescale 1ns/1ps

// =========================================================
// register file and flags side: operands held only while busy
module adc_operand_model (
    input wire logic busy,
    input wire logic [23:0] vals,
    output logic [7:0] dst_data,
    output logic [7:0] src_data,
    output logic [7:0] flags_in
);
    // idle operand lines carry inverted values so stale data never matches
    assign {dst_data, src_data, flags_in} = busy ? vals : ~vals;
endmodule // adc_operand_model

// File: adc_decode_test.sv
`timescale 1ns/1ps

// =========================================================
// self-checking bench for the add-with-carry decoder
module adc_decode_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] opcode = 8'h00;
    logic opcode_valid = 1'b0;
    logic [23:0] vals = 24'h000000;
    logic [7:0] dst_data, src_data, flags_in, wb_data, flags_out;
    logic busy, illegal, wb_valid, flags_we;
    logic [2:0] fetch_cycles, exec_cycles;
    logic [1:0] dst_mode, src_mode;
    int mismatches = 0;
    int check_count = 0;
    int run = 0;
    integer seed = 32'h4062;
    logic [30:0] exp_q[$];
    logic [30:0] note;
    logic [23:0] edge_vals[4] = '{24'hff0080, 24'h7f0080, 24'h808000, 24'h080783};
    logic [7:0] bad_ops[4] = '{8'h11, 8'h1a, 8'h00, 8'hff};

    always #10 clk = ~clk;

    adc_operand_model adc_operand_model_inst (.busy(busy), .vals(vals), .dst_data(dst_data),
        .src_data(src_data), .flags_in(flags_in));

    adc_decode adc_decode_inst (.CLK(clk), .RESET(reset), .OPCODE(opcode),
        .OPCODE_VALID(opcode_valid), .DST_DATA(dst_data), .SRC_DATA(src_data),
        .FLAGS_IN(flags_in), .BUSY(busy), .FETCH_CYCLES(fetch_cycles),
        .EXEC_CYCLES(exec_cycles), .DST_MODE(dst_mode), .SRC_MODE(src_mode),
        .ILLEGAL(illegal), .WB_VALID(wb_valid), .WB_DATA(wb_data), .FLAGS_WE(flags_we),
        .FLAGS_OUT(flags_out));

    // expected sum and flags byte c z s v d h and two passed bits
    function automatic logic [15:0] expect_wb(input logic [23:0] v);
        logic [8:0] sum;
        logic [4:0] half;
        sum = {1'b0, v[23:16]} + {1'b0, v[15:8]} + {8'h00, v[7]};
        half = {1'b0, v[19:16]} + {1'b0, v[11:8]} + {4'h0, v[7]};
        return {sum[7:0], sum[8], sum[7:0] == 8'h00, sum[7],
            (v[23] == v[15]) && (sum[7] != v[23]), 1'b0, half[4], v[1:0]};
    endfunction

    // fetch, exec, dst mode, src mode for each opcode
    function automatic logic [9:0] expect_dec(input logic [7:0] op);
        case (op)
            8'h12: return {3'h2, 3'h3, 2'h0, 2'h0};
            8'h13: return {3'h2, 3'h4, 2'h0, 2'h1};
            8'h14: return {3'h3, 3'h3, 2'h0, 2'h0};
            8'h15: return {3'h3, 3'h4, 2'h0, 2'h1};
            8'h16: return {3'h3, 3'h3, 2'h0, 2'h2};
            8'h17: return {3'h3, 3'h4, 2'h1, 2'h2};
            8'h18: return {3'h4, 3'h3, 2'h3, 2'h3};
            default: return {3'h4, 3'h3, 2'h3, 2'h2};
        endcase
    endfunction

    task automatic report(input logic [30:0] got, input logic [30:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_wb(input logic [30:0] got, input logic [30:0] exp);
        report(got, exp);
    endtask

    task automatic check_ill(input logic [6:0] got, input logic [6:0] exp);
        report({24'h000000, got}, {24'h000000, exp});
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one instruction; a second request, legal opcode 18h, is held during busy and must be ignored
    task automatic issue(input logic [7:0] op, input logic [23:0] v);
        logic [9:0] d;
        int n;
        d = expect_dec(op);
        opcode = op;
        opcode_valid = 1'b1;
        vals = v;
        exp_q.push_back({1'b0, 4'(d[9:7] + d[6:4]), d, expect_wb(v)});
        @(negedge clk);
        opcode = 8'h18;
        n = 0;
        while (wb_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic refuse(input logic [7:0] op);
        opcode = op;
        opcode_valid = 1'b1;
        exp_q.push_back({1'b1, 30'h00000000});
        @(negedge clk);
    endtask

    // monitor: every pulse takes the oldest note off the queue
    always @(posedge clk) begin
        #1;
        if (busy === 1'b1) run++;
        if (wb_valid === 1'b1 || illegal === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 31'h7fffffff;
            if (note[30]) check_ill({illegal, wb_valid, busy, 4'(run)}, 7'h40);
            else check_wb({flags_we, 4'(run), fetch_cycles, exec_cycles, dst_mode,
                src_mode, wb_data, flags_out}, {1'b1, note[29:0]});
            run = 0;
        end
    end

    // main sequence, inputs changed at falling edges
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 24; i++) begin
            issue(8'(8'h12 + i % 8), 24'($random(seed)));
        end
        for (int i = 0; i < 4; i++) begin
            issue(8'(8'h14 + i), edge_vals[i]);
        end
        for (int i = 0; i < 4; i++) begin
            refuse(bad_ops[i]);
        end
        issue(8'h19, 24'hffff80);
        opcode_valid = 1'b0;
        repeat (4) @(negedge clk);
        check_ill(7'(exp_q.size()), 7'h00);
        give_verdict();
    end

    // watchdog well beyond the expected run length
    initial begin
        #(20 * 2000);
        mismatches++;
        give_verdict();
    end
endmodule // adc_decode_test
